// file: rtl/cwo_write_order.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// [RL1] A posted memory write is issued and the next command starts without waiting for it.
// [RL2] A non-posted memory write holds the next command until the write is globally observed.
// [RL3] While a non-posted memory write is pending, command fetch and issue are stalled.
// [RL4] A non-posted write completes only after all earlier posted writes are observed.
// [RL5] Store, copy, indexed, immediate, head, table update and perf report writes are posted.
// [RL6] The atomic command writes posted or non-posted as its option bit selects.
// [RL7] Pipe control post-sync is non-posted when stalling, posted otherwise; flush post-sync is non-posted.
// [RL8] A stalling pipe control or a flush drains all earlier posted writes before completing.
// [RL9] Register load from memory, atomic and semaphore wait first drain earlier memory writes.
// [RL10] Software makes earlier writes observed before batch start or conditional batch end.
// [RL11] Software uses non-posted writes sparingly, one just before the consumer.
// [RL12] Register-writing commands finish their register update before the next command starts.
// [RL13] Register load from memory writes its register posted or non-posted per its async bit.
// [RL14] Register-reading commands always see the most recent register value.
// [RL15] Software sets the async bit so that later consumers of the loaded register stay ordered.
// [RL16] Outstanding posted writes are counted; a non-posted write needs its own ack and a zero count.
module cwo_write_order
	import cwo_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic                 cmdValid,
	output logic                      cmdReady,
	input  wire logic [CWO_CMD_W-1:0] cmdKind,
	input  wire logic                 cmdPostSync,
	input  wire logic                 cmdStalling,
	input  wire logic                 cmdNonPostedSel,
	input  wire logic                 cmdAsyncMode,
	output logic                      memWrReq,
	output logic                      memWrNonPosted,
	input  wire logic                 memWrGrant,
	input  wire logic                 memWrAck,
	output logic                      regWrReq,
	output logic                      regWrPosted,
	input  wire logic                 regWrGrant,
	input  wire logic                 regWrAck,
	output logic                      fetchStall,
	output logic [CWO_CNT_W-1:0]      postedCount,
	output logic                      regPending,
	output logic                      busy
);

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	cwo_cmd_t kind;
	logic     wantMem;
	logic     memNonPosted;
	logic     wantReg;
	logic     regNonPosted;
	logic     drainFirst;
	logic     drainAfter;

	always_comb begin
		kind         = cwo_cmd_t'(cmdKind);
		wantMem      = 1'b0;
		memNonPosted = 1'b0;
		wantReg      = 1'b0;
		regNonPosted = 1'b0;
		drainFirst   = 1'b0;
		drainAfter   = 1'b0;
		case (kind)
			CWO_CMD_STORE_REG_TO_MEM, CWO_CMD_MEM_COPY, CWO_CMD_INDEXED_STORE,
			CWO_CMD_IMMEDIATE_STORE, CWO_CMD_HEAD_REPORT, CWO_CMD_XLAT_TABLE_UPDATE,
			CWO_CMD_PERF_COUNTER_REPORT: begin
				wantMem = 1'b1; // [RL5]
			end
			CWO_CMD_ATOMIC_MEMORY: begin
				drainFirst   = 1'b1; // [RL9]
				wantMem      = 1'b1;
				memNonPosted = cmdNonPostedSel; // [RL6]
			end
			CWO_CMD_FLUSH, CWO_CMD_FLUSH_WORD: begin
				wantMem      = cmdPostSync;
				memNonPosted = 1'b1; // [RL7]
				drainAfter   = 1'b1; // [RL8]
			end
			CWO_CMD_PIPE_CONTROL: begin
				wantMem      = cmdPostSync;
				memNonPosted = cmdStalling; // [RL7]
				drainAfter   = cmdStalling; // [RL8]
				wantReg      = 1'b1;
				regNonPosted = 1'b1; // [RL12]
			end
			CWO_CMD_REG_LOAD_FROM_MEM: begin
				drainFirst   = 1'b1; // [RL9]
				wantReg      = 1'b1;
				regNonPosted = ~cmdAsyncMode; // [RL13]
			end
			CWO_CMD_SEMAPHORE_WAIT: begin
				drainFirst = 1'b1; // [RL9]
			end
			CWO_CMD_IMMEDIATE_REG_LOAD, CWO_CMD_ARITHMETIC, CWO_CMD_REGISTER_COPY: begin
				wantReg      = 1'b1;
				regNonPosted = 1'b1; // [RL12]
			end
			default: begin
			end
		endcase
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PRE_DRAIN,
		ST_MEM_ISSUE,
		ST_MEM_WAIT,
		ST_REG_ISSUE,
		ST_REG_WAIT,
		ST_POST_DRAIN
	} cwo_state_t;

	cwo_state_t state;
	cwo_state_t next_state;
	logic       hMem;
	logic       hMemNp;
	logic       hReg;
	logic       hRegNp;
	logic       hDrainAfter;
	logic       hDrainFirst;
	logic       ackSeen;
	logic       postedDone;

	logic accept;
	assign accept = cmdValid && cmdReady;

	// Register reads are only started once no register write is in flight.
	assign cmdReady   = (state == ST_IDLE) && !regPending; // [RL14]
	assign fetchStall = (state != ST_IDLE); // [RL3]
	assign busy       = (state != ST_IDLE) || (postedCount != CWO_CNT_ZERO);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hMem        <= 1'b0;
			hMemNp      <= 1'b0;
			hReg        <= 1'b0;
			hRegNp      <= 1'b0;
			hDrainAfter <= 1'b0;
			hDrainFirst <= 1'b0;
		end else if (accept) begin
			hMem        <= wantMem;
			hMemNp      <= memNonPosted;
			hReg        <= wantReg;
			hRegNp      <= regNonPosted;
			hDrainAfter <= drainAfter;
			hDrainFirst <= drainFirst;
		end
	end

	// A drain completes once no posted write is still outstanding.
	logic drained;
	assign drained = (postedCount == CWO_CNT_ZERO);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (accept) begin
					if (drainFirst) begin
						next_state = ST_PRE_DRAIN;
					end else if (wantMem) begin
						next_state = ST_MEM_ISSUE;
					end else if (wantReg) begin
						next_state = ST_REG_ISSUE;
					end else if (drainAfter) begin
						next_state = ST_POST_DRAIN;
					end
				end
			end
			ST_PRE_DRAIN: begin
				if (drained) begin // [RL9]
					if (hMem) begin
						next_state = ST_MEM_ISSUE;
					end else if (hReg) begin
						next_state = ST_REG_ISSUE;
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_MEM_ISSUE: begin
				if (memWrGrant) begin
					if (hMemNp) begin
						next_state = ST_MEM_WAIT; // [RL2]
					end else if (hReg) begin
						next_state = ST_REG_ISSUE;
					end else if (hDrainAfter) begin
						next_state = ST_POST_DRAIN;
					end else begin
						next_state = ST_IDLE; // [RL1]
					end
				end
			end
			ST_MEM_WAIT: begin
				if ((ackSeen || memWrAck) && drained) begin // [RL4] [RL16]
					if (hReg) begin
						next_state = ST_REG_ISSUE;
					end else if (hDrainAfter) begin
						next_state = ST_POST_DRAIN;
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_REG_ISSUE: begin
				if (regWrGrant) begin
					if (hRegNp) begin
						next_state = ST_REG_WAIT; // [RL12]
					end else if (hDrainAfter) begin
						next_state = ST_POST_DRAIN;
					end else begin
						next_state = ST_IDLE; // [RL13]
					end
				end
			end
			ST_REG_WAIT: begin
				if (regWrAck) begin
					next_state = hDrainAfter ? ST_POST_DRAIN : ST_IDLE;
				end
			end
			ST_POST_DRAIN: begin
				if (drained) begin // [RL8]
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Write request outputs
	// ------------------------------------------------------------
	assign memWrReq       = (state == ST_MEM_ISSUE);
	assign memWrNonPosted = hMemNp;
	assign regWrReq       = (state == ST_REG_ISSUE);
	assign regWrPosted    = ~hRegNp;

	// Acks come back in issue order, so while posted writes are still counted an ack
	// belongs to one of them; only an ack with a zero count is the non-posted write's own.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ackSeen <= 1'b0;
		end else if (state != ST_MEM_WAIT) begin
			ackSeen <= 1'b0;
		end else if (memWrAck && drained) begin
			ackSeen <= 1'b1; // [RL4]
		end
	end

	// ------------------------------------------------------------
	// Outstanding posted memory write count
	// ------------------------------------------------------------
	logic postedIssue;
	assign postedIssue  = memWrReq && memWrGrant && !hMemNp; // [RL1]
	// Acks in ST_MEM_WAIT belong to the non-posted write only once the posted count is zero and its own ack is not yet seen.
	assign postedDone   = memWrAck && !(state == ST_MEM_WAIT && !ackSeen && drained);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			postedCount <= CWO_CNT_ZERO;
		end else begin
			case ({postedIssue, postedDone && (postedCount != CWO_CNT_ZERO)})
				2'b10: postedCount <= (postedCount == CWO_CNT_MAX) ? postedCount
				                       : postedCount + 8'h01; // [RL16]
				2'b01: postedCount <= postedCount - 8'h01; // [RL16]
				default: postedCount <= postedCount;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Posted register write tracking
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regPending <= 1'b0;
		end else if (regWrReq && regWrGrant && !hRegNp) begin
			regPending <= 1'b1; // [RL13]
		end else if (regWrAck && state != ST_REG_WAIT) begin
			regPending <= 1'b0; // [RL14]
		end
	end

endmodule : cwo_write_order

`default_nettype wire

// file: rtl/cwo_pkg.sv
`default_nettype none

package cwo_pkg;

	// ------------------------------------------------------------
	// Command classes
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		CWO_CMD_NOP,
		CWO_CMD_STORE_REG_TO_MEM,
		CWO_CMD_MEM_COPY,
		CWO_CMD_INDEXED_STORE,
		CWO_CMD_IMMEDIATE_STORE,
		CWO_CMD_HEAD_REPORT,
		CWO_CMD_XLAT_TABLE_UPDATE,
		CWO_CMD_PERF_COUNTER_REPORT,
		CWO_CMD_ATOMIC_MEMORY,
		CWO_CMD_FLUSH,
		CWO_CMD_FLUSH_WORD,
		CWO_CMD_PIPE_CONTROL,
		CWO_CMD_REG_LOAD_FROM_MEM,
		CWO_CMD_BATCH_START,
		CWO_CMD_COND_BATCH_END,
		CWO_CMD_SEMAPHORE_WAIT,
		CWO_CMD_IMMEDIATE_REG_LOAD,
		CWO_CMD_ARITHMETIC,
		CWO_CMD_REGISTER_COPY,
		CWO_CMD_PREDICATE,
		CWO_CMD_SET_PREDICATE
	} cwo_cmd_t;

	localparam int CWO_CMD_W       = 5;
	localparam int CWO_CNT_W       = 8;
	localparam logic [CWO_CNT_W-1:0] CWO_CNT_MAX  = 8'hFF;
	localparam logic [CWO_CNT_W-1:0] CWO_CNT_ZERO = 8'h00;

endpackage : cwo_pkg

`default_nettype wire

// file: test/cwo_write_order_props.sv
`timescale 1ns/1ps
`default_nettype none
module cwo_write_order_props
	import cwo_pkg::*;
(
	input wire logic                 clk,
	input wire logic                 sys_rst,
	input wire logic                 cmdValid,
	input wire logic                 cmdReady,
	input wire logic [CWO_CMD_W-1:0] cmdKind,
	input wire logic                 memWrReq,
	input wire logic                 memWrNonPosted,
	input wire logic                 memWrGrant,
	input wire logic                 memWrAck,
	input wire logic                 regWrReq,
	input wire logic                 regWrGrant,
	input wire logic                 fetchStall,
	input wire logic [CWO_CNT_W-1:0] postedCount,
	input wire logic                 regPending,
	input wire logic                 busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic memGo;
	assign memGo = memWrReq && memWrGrant;
	property p_memHold; memWrReq && !memWrGrant |=> memWrReq && $stable(memWrNonPosted); endproperty
	a_memHold: assert property (p_memHold) else $error("memHold");
	property p_regHold; regWrReq && !regWrGrant |=> regWrReq; endproperty
	a_regHold: assert property (p_regHold) else $error("regHold");
	property p_stall; memWrReq |-> fetchStall && !cmdReady; endproperty
	a_stall: assert property (p_stall) else $error("stall");
	property p_post;
		cmdValid && cmdReady
		&& cmdKind inside {[CWO_CMD_STORE_REG_TO_MEM:CWO_CMD_PERF_COUNTER_REPORT]}
		|=> memWrReq && !memWrNonPosted;
	endproperty
	a_post: assert property (p_post) else $error("post");
	property p_inc; memGo && !memWrNonPosted && !memWrAck |=> postedCount == $past(postedCount) + 8'h01; endproperty
	a_inc: assert property (p_inc) else $error("inc");
	property p_dec; memWrAck && !memGo && postedCount != 8'h00 |=> postedCount == $past(postedCount) - 8'h01; endproperty
	a_dec: assert property (p_dec) else $error("dec");
	property p_regOrder; regWrReq || regPending |-> !cmdReady; endproperty
	a_regOrder: assert property (p_regOrder) else $error("regOrder");
	property p_busy; postedCount != 8'h00 |-> busy; endproperty
	a_busy: assert property (p_busy) else $error("busy");
	property p_npWait; memWrNonPosted && fetchStall && postedCount != 8'h00 |=> fetchStall; endproperty
	a_npWait: assert property (p_npWait) else $error("npWait");
	c_np: cover property (memGo && memWrNonPosted);
	c_drain: cover property (fetchStall && postedCount > 8'h01 && !memWrReq);
	c_reg: cover property (regWrReq && regWrGrant);
endmodule : cwo_write_order_props
bind cwo_write_order cwo_write_order_props u_props (.clk, .sys_rst, .cmdValid, .cmdReady,
	.cmdKind, .memWrReq, .memWrNonPosted, .memWrGrant, .memWrAck, .regWrReq, .regWrGrant,
	.fetchStall, .postedCount, .regPending, .busy);
`default_nettype wire

// file: test/cwo_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
module cwo_fabric_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic fast,
	input wire logic ackHold,
	input wire logic memWrReq,
	output logic     memWrGrant = 1'b0,
	output logic     memWrAck = 1'b0,
	input wire logic regWrReq,
	output logic     regWrGrant = 1'b0,
	output logic     regWrAck = 1'b0,
	output logic     regOut = 1'b0
);
	int memOut = 0;
	// Writes reach observation in the order they were taken.
	always @(posedge clk) begin
		memOut = sys_rst ? 0 : memOut + int'(memWrReq && memWrGrant) - int'(memWrAck);
		regOut = !sys_rst && (regOut ? !regWrAck : regWrReq && regWrGrant);
		memWrGrant <= #1 !sys_rst && memWrReq && !memWrGrant && (fast || $urandom % 3 == 0);
		memWrAck <= #1 !sys_rst && !ackHold && memOut > 0 && $urandom % 2 == 0;
		regWrGrant <= #1 !sys_rst && regWrReq && !regWrGrant && (fast || $urandom % 2 == 0);
		regWrAck <= #1 regOut && $urandom % 2 == 0;
	end
endmodule : cwo_fabric_model
`default_nettype wire

// file: test/command_write_ordering_test.sv
`timescale 1ns/1ps
`default_nettype none
module command_write_ordering_test;
	import cwo_pkg::*;
	logic                 clk, sys_rst, cmdValid, cmdReady, cmdPostSync, cmdStalling;
	logic                 cmdNonPostedSel, cmdAsyncMode, memWrReq, memWrNonPosted, memWrGrant;
	logic                 memWrAck, regWrReq, regWrPosted, regWrGrant, regWrAck, fetchStall;
	logic                 regPending, busy, fast, ackHold, regOut;
	logic [CWO_CMD_W-1:0] cmdKind;
	logic [CWO_CNT_W-1:0] postedCount;
	int                   n_errors, num_checks, cycles;
	logic                 expMem[$], expReg[$];
	cwo_cmd_t             k;
	logic [7:0]           want;
	cwo_write_order  u_cwo_write_order (.*);
	cwo_fabric_model u_cwo_fabric_model (.*);
	always #2.5 clk = !clk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	// ----------------------------------------
	// Command driver: f is {async, npSel, stalling, postSync}.
	// ----------------------------------------
	task automatic send(input cwo_cmd_t c, input logic [3:0] f);
		logic dr;
		if (c == CWO_CMD_FLUSH_WORD) f[0] = 1'b0;
		if (c inside {[CWO_CMD_STORE_REG_TO_MEM:CWO_CMD_PERF_COUNTER_REPORT]}) expMem.push_back(1'b0);
		if (c == CWO_CMD_ATOMIC_MEMORY) expMem.push_back(f[2]);
		if (c == CWO_CMD_FLUSH && f[0]) expMem.push_back(1'b1);
		if (c == CWO_CMD_PIPE_CONTROL && f[0]) expMem.push_back(f[1]);
		if (c == CWO_CMD_REG_LOAD_FROM_MEM) expReg.push_back(f[3]);
		if (c inside {CWO_CMD_IMMEDIATE_REG_LOAD, CWO_CMD_ARITHMETIC, CWO_CMD_REGISTER_COPY,
			CWO_CMD_PIPE_CONTROL}) expReg.push_back(1'b0);
		dr = (c == CWO_CMD_PIPE_CONTROL && f[1]) || (c == CWO_CMD_ATOMIC_MEMORY && f[2])
			|| c inside {CWO_CMD_FLUSH, CWO_CMD_FLUSH_WORD, CWO_CMD_REG_LOAD_FROM_MEM,
			CWO_CMD_SEMAPHORE_WAIT};
		@(posedge clk);
		#1;
		cmdKind = c;
		{cmdAsyncMode, cmdNonPostedSel, cmdStalling, cmdPostSync} = f;
		cmdValid = 1'b1;
		do @(negedge clk); while (cmdReady !== 1'b1);
		@(posedge clk);
		#1;
		cmdValid = 1'b0;
		do @(negedge clk); while (cmdReady !== 1'b1);
		if (dr) chk(postedCount, 8'h00);
		if (dr) chk(8'(u_cwo_fabric_model.memOut), 8'h00);
		if (c == CWO_CMD_ATOMIC_MEMORY && !f[2]) chk(postedCount, 8'h01);
		chk({7'h00, regOut}, 8'h00);
	endtask : send
	always @(negedge clk) begin
		if (memWrReq && memWrGrant) begin
			want = expMem.size() ? {7'h00, expMem.pop_front()} : 8'hXX;
			chk({7'h00, memWrNonPosted}, want);
		end
		if (regWrReq && regWrGrant) begin
			want = expReg.size() ? {7'h00, expReg.pop_front()} : 8'hXX;
			chk({7'h00, regWrPosted}, want);
		end
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		{clk, cmdValid, cmdPostSync, cmdStalling, cmdNonPostedSel, cmdAsyncMode, ackHold} = '0;
		{sys_rst, fast} = 2'h3;
		cmdKind = CWO_CMD_NOP;
		{n_errors, num_checks, cycles} = '0;
		void'($urandom(32'hD3540F2F));
		repeat (3) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		ackHold = 1'b1;
		send(CWO_CMD_IMMEDIATE_STORE, 4'h0);
		chk(postedCount, 8'h01);
		chk({6'h00, fetchStall, busy}, 8'h01);
		send(CWO_CMD_MEM_COPY, 4'h0);
		chk(postedCount, 8'h02);
		fork
			send(CWO_CMD_ATOMIC_MEMORY, 4'h4);
			begin
				repeat (20) @(negedge clk);
				chk({6'h00, fetchStall, cmdReady}, 8'h02);
				@(posedge clk);
				#1;
				ackHold = 1'b0;
			end
		join
		send(CWO_CMD_REG_LOAD_FROM_MEM, 4'h0);
		send(CWO_CMD_PREDICATE, 4'h0);
		for (int i = 0; i < 300; i++) begin
			k = cwo_cmd_t'($urandom % 21);
			fast = i < 150;
			if (k inside {CWO_CMD_BATCH_START, CWO_CMD_COND_BATCH_END}) send(CWO_CMD_FLUSH, 4'h0);
			send(k, 4'($urandom));
		end
		chk(8'(expMem.size() + expReg.size()), 8'h00);
		end_sim();
	end
endmodule : command_write_ordering_test
`default_nettype wire
